//--- hdl/dlsb_defines.svh
// register offsets, reset values and timing counts of the drive link status bank
`ifndef DLSB_DEFINES_SVH
`define DLSB_DEFINES_SVH
`define DLSB_OFF_FLAGS 12'h000
`define DLSB_OFF_TYPE 12'h004
`define DLSB_OFF_VERSION 12'h008
`define DLSB_OFF_TIMEOUT 12'h00c
`define DLSB_OFF_OWNER 12'h010
`define DLSB_OFF_ERRCODE 12'h014
`define DLSB_OFF_ERRSTEP 12'h018
`define DLSB_BIT_DONE 0
`define DLSB_BIT_PRESENT 1
`define DLSB_BIT_UNUSED 2
`define DLSB_BIT_BUSY 3
`define DLSB_BIT_ERROR 4
`define DLSB_BIT_STICKY 5
`define DLSB_RST_TIMEOUT 16'h0001
`define DLSB_RST_ERRSTEP 16'hffff
`define DLSB_ERR_NONE 16'h0000
`define DLSB_ERR_TIMEOUT 16'h0002
`define DLSB_CLK_HZ 125000000
`define DLSB_TICK_MS 100
`define DLSB_TICK_CYCLES ((`DLSB_CLK_HZ / 1000) * `DLSB_TICK_MS)
`endif

//--- hdl/dlsb_pkg.sv
// types of the drive link status bank
package dlsb_pkg;
    typedef enum logic [2:0] {
        DLSB_IDLE = 3'b001,
        DLSB_WAIT = 3'b010,
        DLSB_DONE = 3'b100
    } dlsb_state_e;

    // command request from the scan engine
    typedef struct packed {
        logic start;
        logic [15:0] step;
    } dlsb_cmd_s;

    // outcome reported by the link engine
    typedef struct packed {
        logic finish;
        logic commError;
        logic [15:0] code;
    } dlsb_result_s;
endpackage

//--- hdl/drive_link_status_bank.sv
// status and control bank for the drive command link
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`include "dlsb_defines.svh"
module dlsb_drive_link_status_bank #(
    parameter int TICK_CYCLES = `DLSB_TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // scan timing and mode
    input wire logic scanEnd,
    input wire logic runMode,
    // cassette pins and data
    input wire logic cassettePresentPin,
    input wire logic [15:0] cassetteTypeIn,
    input wire logic [15:0] cassetteVersionIn,
    // command and link
    input wire dlsb_pkg::dlsb_cmd_s cmd,
    output logic cmdAccepted,
    input wire dlsb_pkg::dlsb_result_s result,
    input wire logic replyStarted,
    output logic abortLink,
    // flag outputs
    output logic completionPulse,
    output logic portBusy
);
    // ==========================================
    // state
    dlsb_pkg::dlsb_state_e state;
    logic [2:0] presSync;
    logic present;
    logic prevRun;
    logic stopToRun;
    logic errorFlag;
    logic stickyLatch;
    logic [15:0] typeCode;
    logic [15:0] versionCode;
    logic [15:0] responseTimeout;
    logic [15:0] ownerStep;
    logic [15:0] errorCode;
    logic [15:0] errorStep;
    logic [31:0] tickCount;
    logic [15:0] unitCount;
    logic tick;
    logic timedOut;
    logic finishNow;
    logic [15:0] finishCode;
    logic finishErr;
    logic donePending;
    logic [15:0] effTimeout;

    // signed check of the timeout setting
    function automatic logic [15:0] effective_timeout(input logic [15:0] v);
        effective_timeout = ($signed(v) <= 16'sh0000) ? 16'h0001 : v;
    endfunction

    // ==========================================
    // pin synchroniser for the cassette detect
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            presSync <= 3'h0;
            present <= 1'b0;
        end else begin
            presSync <= {presSync[1:0], cassettePresentPin};
            if (presSync[1] == presSync[2]) begin
                present <= presSync[2];
            end
        end
    end

    // cassette identity shown only while attached
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            typeCode <= 16'h0000;
            versionCode <= 16'h0000;
        end else begin
            typeCode <= present ? cassetteTypeIn : 16'h0000;
            versionCode <= present ? cassetteVersionIn : 16'h0000;
        end
    end

    // stop-to-run edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prevRun <= 1'b0;
        end else begin
            prevRun <= runMode;
        end
    end
    assign stopToRun = runMode && !prevRun;

    // ==========================================
    // command sequencing
    assign effTimeout = effective_timeout(responseTimeout);
    assign cmdAccepted = (state == dlsb_pkg::DLSB_IDLE) && cmd.start && present;
    assign tick = (tickCount == 32'(TICK_CYCLES - 1));
    assign timedOut = (state == dlsb_pkg::DLSB_WAIT) && tick && (unitCount + 16'h0001 >= effTimeout);
    assign finishNow = (state == dlsb_pkg::DLSB_WAIT) && (result.finish || timedOut);
    assign abortLink = timedOut && !result.finish;
    // timeout after a started reply records code two
    assign finishCode = result.finish ? result.code :
        (replyStarted ? `DLSB_ERR_TIMEOUT : 16'h0001);
    assign finishErr = result.finish ? (result.commError || result.code != `DLSB_ERR_NONE) : 1'b1;
    assign portBusy = (state == dlsb_pkg::DLSB_WAIT);

    // state machine
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= dlsb_pkg::DLSB_IDLE;
        end else begin
            case (state)
                dlsb_pkg::DLSB_IDLE: begin
                    if (cmdAccepted) begin
                        state <= dlsb_pkg::DLSB_WAIT;
                    end
                end
                dlsb_pkg::DLSB_WAIT: begin
                    if (finishNow) begin
                        state <= dlsb_pkg::DLSB_DONE;
                    end
                end
                dlsb_pkg::DLSB_DONE: begin
                    state <= dlsb_pkg::DLSB_IDLE;
                end
                default: begin
                    state <= dlsb_pkg::DLSB_IDLE;
                end
            endcase
        end
    end

    // 100 ms tick and unit counter for the reply wait
    always_ff @(posedge ref_clk) begin
        if (reset || state != dlsb_pkg::DLSB_WAIT) begin
            tickCount <= 32'h0;
            unitCount <= 16'h0;
        end else if (tick) begin
            tickCount <= 32'h0;
            unitCount <= unitCount + 16'h0001;
        end else begin
            tickCount <= tickCount + 32'h1;
        end
    end

    // owner step captured when the port goes busy
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ownerStep <= 16'h0000;
        end else if (cmdAccepted) begin
            ownerStep <= cmd.step;
        end
    end

    // completion pulse lasts one scan after the finish
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            donePending <= 1'b0;
            completionPulse <= 1'b0;
        end else begin
            // a finish landing on a scan end waits for the following scan
            donePending <= finishNow || (donePending && !scanEnd);
            if (scanEnd) begin
                completionPulse <= donePending;
            end
        end
    end

    // error flag and code
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            errorFlag <= 1'b0;
            errorCode <= `DLSB_ERR_NONE;
        end else begin
            // flag: finish wins, else the next accepted command clears it
            if (finishNow) begin
                errorFlag <= finishErr;
            end else if (cmdAccepted) begin
                errorFlag <= 1'b0;
            end
            // code: finish wins, else the mode change clears it
            if (finishNow) begin
                errorCode <= finishErr ? finishCode : `DLSB_ERR_NONE;
            end else if (stopToRun) begin
                errorCode <= `DLSB_ERR_NONE;
            end
        end
    end

    // sticky latch and failing step; the set wins over the mode clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stickyLatch <= 1'b0;
            errorStep <= `DLSB_RST_ERRSTEP;
        end else if (finishNow && finishErr) begin
            stickyLatch <= 1'b1;
            errorStep <= ownerStep;
        end else if (stopToRun) begin
            stickyLatch <= 1'b0;
            errorStep <= `DLSB_RST_ERRSTEP;
        end
    end

    // ==========================================
    // apb register access, zero wait state
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // timeout register write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            responseTimeout <= `DLSB_RST_TIMEOUT;
        end else if (psel && penable && pwrite && paddr == `DLSB_OFF_TIMEOUT) begin
            responseTimeout <= pwdata[15:0];
        end
    end

    // read data from flip-flops, taken in the setup cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                `DLSB_OFF_FLAGS: begin
                    prdata <= {26'h0, stickyLatch, errorFlag, portBusy, 1'b0, present,
                        completionPulse};
                end
                `DLSB_OFF_TYPE: prdata <= {16'h0, typeCode};
                `DLSB_OFF_VERSION: prdata <= {16'h0, versionCode};
                `DLSB_OFF_TIMEOUT: prdata <= {16'h0, responseTimeout};
                `DLSB_OFF_OWNER: prdata <= {16'h0, ownerStep};
                `DLSB_OFF_ERRCODE: prdata <= {16'h0, errorCode};
                `DLSB_OFF_ERRSTEP: prdata <= {16'h0, errorStep};
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule // dlsb_drive_link_status_bank

//--- testbench/dlsb_assertions.sv
// port checker of the drive link status bank
`timescale 1ns/100ps
module dlsb_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // command and flags
    input wire logic cmdAccepted,
    input wire dlsb_pkg::dlsb_result_s result,
    input wire logic abortLink,
    input wire logic cassettePresentPin,
    input wire logic scanEnd,
    input wire logic completionPulse,
    input wire logic portBusy
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // ==========
    // command port
    accept_sets_busy_a: assert property (cmdAccepted |=> portBusy)
        else $error("no busy after accept");
    busy_blocks_a: assert property (portBusy |-> !cmdAccepted)
        else $error("accept while busy");
    absent_refuses_a: assert property (!cassettePresentPin [*6] |-> !cmdAccepted)
        else $error("accept without cassette");
    busy_holds_a: assert property (portBusy && !result.finish && !abortLink |=> portBusy)
        else $error("busy dropped early");
    finish_frees_a: assert property (portBusy && result.finish |=> !portBusy)
        else $error("busy kept after finish");
    abort_ends_a: assert property (abortLink |-> portBusy ##1 !portBusy)
        else $error("abort outside wait");
    // ==========
    // completion flag
    pulse_holds_a: assert property (completionPulse && !scanEnd |=> completionPulse)
        else $error("pulse shorter than scan");
    pulse_at_scan_a: assert property ($rose(completionPulse) |-> $past(scanEnd))
        else $error("pulse off scan edge");
endmodule // dlsb_assertions
bind dlsb_drive_link_status_bank dlsb_assertions u_dlsb_assertions (
    .ref_clk, .reset, .cmdAccepted, .result, .abortLink, .cassettePresentPin,
    .scanEnd, .completionPulse, .portBusy
);

//--- testbench/dlsb_drive_model.sv
// behavioural drive answering link commands
`timescale 1ns/100ps
module dlsb_drive_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // link side
    input wire logic cmdAccepted,
    input wire logic portBusy,
    input wire logic [1:0] mode,
    output dlsb_pkg::dlsb_result_s result,
    output logic replyStarted
);
    logic [3:0] cnt;
    // ==========
    // free counter restarted by each accept
    always_ff @(posedge ref_clk) begin
        if (reset || cmdAccepted) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    // mode 0 good, 1 error reply, 2 reply cut short
    // code lines toggle outside the reply
    always_comb begin
        result.finish = portBusy && cnt == 4'h3 && mode != 2'h2;
        result.commError = result.finish && mode == 2'h1;
        result.code = result.finish ? {7'h00, mode[0], 5'h00, mode[0], 2'h0} : {4{cnt}};
    end
    assign replyStarted = portBusy && mode == 2'h2;
endmodule // dlsb_drive_model

//--- testbench/tb_drive_link_status_bank.sv
// self-checking bench of the drive link status bank
`timescale 1ns/100ps
`include "dlsb_defines.svh"
`define CHK(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("mismatch at %0t: %h %h", $time, g, e); \
        end \
    end
module tb_drive_link_status_bank;
    logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, expv;
    logic pready, scanEnd = 1'b0, runMode = 1'b1, cassettePresentPin = 1'b0;
    logic [15:0] cassetteTypeIn = 16'h0, cassetteVersionIn = 16'h0, step;
    logic [15:0] seed = 16'hbfb4;
    dlsb_pkg::dlsb_cmd_s cmd = '0;
    dlsb_pkg::dlsb_result_s result;
    logic cmdAccepted, replyStarted, abortLink, completionPulse, portBusy;
    logic [1:0] mode = 2'h0;
    logic [3:0] scanCnt = 4'h0;
    logic [31:0] q[$];
    int fails = 0, n_tests = 0;
    dlsb_drive_link_status_bank #(.TICK_CYCLES(10)) u_dlsb_drive_link_status_bank (
        .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr(), .scanEnd, .runMode, .cassettePresentPin, .cassetteTypeIn,
        .cassetteVersionIn, .cmd, .cmdAccepted, .result, .replyStarted, .abortLink,
        .completionPulse, .portBusy
    );
    dlsb_drive_model u_dlsb_drive_model (
        .ref_clk, .reset, .cmdAccepted, .portBusy, .mode, .result, .replyStarted
    );
    // clock and scan ends every sixteen cycles
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        scanCnt <= scanCnt + 4'h1;
        scanEnd <= scanCnt == 4'hf;
    end
    // read data against the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            expv = q.pop_front();
            `CHK(prdata, expv)
        end
    end
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction
    // apb cycle, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // one command through to its completion flag
    task automatic op(input logic [1:0] m);
        do @(negedge ref_clk); while (completionPulse !== 1'b0);
        @(posedge ref_clk);
        step = xs();
        mode <= m;
        cmd <= {1'b1, step};
        do @(negedge ref_clk); while (cmdAccepted !== 1'b1);
        @(posedge ref_clk);
        cmd.start <= 1'b0;
        do @(negedge ref_clk); while (completionPulse !== 1'b1);
        @(posedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(`DLSB_OFF_ERRSTEP, 32'hffff);
        cmd <= {1'b1, 16'h0001};
        repeat (8) @(posedge ref_clk);
        rd(`DLSB_OFF_FLAGS, 32'h0);
        cmd.start <= 1'b0;
        cassettePresentPin <= 1'b1;
        cassetteTypeIn <= xs();
        cassetteVersionIn <= xs();
        repeat (8) @(posedge ref_clk);
        rd(`DLSB_OFF_TYPE, {16'h0, cassetteTypeIn});
        rd(`DLSB_OFF_VERSION, {16'h0, cassetteVersionIn});
        rd(12'h01c, 32'h0);
        apb(1'b1, `DLSB_OFF_TIMEOUT, 32'h7fff);
        rd(`DLSB_OFF_TIMEOUT, 32'h7fff);
        $display("test reset and cassette done");
        op(2'h0);
        rd(`DLSB_OFF_FLAGS, 32'h3);
        rd(`DLSB_OFF_OWNER, {16'h0, step});
        rd(`DLSB_OFF_ERRCODE, 32'h0);
        op(2'h1);
        rd(`DLSB_OFF_FLAGS, 32'h33);
        rd(`DLSB_OFF_ERRCODE, 32'h104);
        rd(`DLSB_OFF_ERRSTEP, {16'h0, step});
        op(2'h0);
        rd(`DLSB_OFF_FLAGS, 32'h23);
        $display("test commands done");
        apb(1'b1, `DLSB_OFF_TIMEOUT, 32'h0);
        op(2'h2);
        rd(`DLSB_OFF_ERRCODE, 32'h2);
        rd(`DLSB_OFF_FLAGS, 32'h33);
        runMode <= 1'b0;
        repeat (2) @(posedge ref_clk);
        runMode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(`DLSB_OFF_ERRCODE, 32'h0);
        rd(`DLSB_OFF_ERRSTEP, 32'hffff);
        do @(negedge ref_clk); while (completionPulse !== 1'b0);
        @(posedge ref_clk);
        rd(`DLSB_OFF_FLAGS, 32'h12);
        $display("test timeout and mode change done");
        end_of_test();
    end
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end
endmodule // tb_drive_link_status_bank
